// *** include/iadsr_defs.vh ***
// Purpose: shared constants of the i2c address decode and broadcast reset block
// Assumes: 7-bit i2c addressing, address select pins classified into four tie levels
// Notes:   included by bare name; definitions only
`ifndef IADSR_DEFS_VH
`define IADSR_DEFS_VH

// ****************************************************************
// synchroniser
// ****************************************************************
`define IADSR_SYNC_W        5
// clocks after reset before the synchroniser output reflects the pins
`define IADSR_WARM_W        4

// ****************************************************************
// address select pin tie classes (bit 1 = tied to a bus line)
// ****************************************************************
`define IADSR_CLS_LOW       2'h0
`define IADSR_CLS_HIGH      2'h1
`define IADSR_CLS_SCL       2'h2
`define IADSR_CLS_SDA       2'h3

// ****************************************************************
// upper address nibble, selected by which pins are tied to bus lines
// index is {pin2 on bus, pin1 on bus, pin0 on bus}
// ****************************************************************
`define IADSR_GRP_000       4'h4
`define IADSR_GRP_001       4'h5
`define IADSR_GRP_010       4'h2
`define IADSR_GRP_011       4'h3
`define IADSR_GRP_100       4'hc
`define IADSR_GRP_101       4'he
`define IADSR_GRP_110       4'ha
`define IADSR_GRP_111       4'hb

// ****************************************************************
// reserved bus codes
// ****************************************************************
`define IADSR_GC_WRITE      8'h00
`define IADSR_GC_READ       8'h01
`define IADSR_RESET_BYTE    8'h06
`define IADSR_ID_ADDR       7'h7c

// ****************************************************************
// byte framing
// ****************************************************************
`define IADSR_BITS_W        4
`define IADSR_BYTE_BITS     4'h8

`endif

// *** rtl/iadsr_pin_class.v ***
// Purpose: decide how one address select pin is tied: low, high, scl or sda
// Assumes: pin, scl and sda are filtered through identical synchroniser paths
// Notes:   evidence is sticky from power-up; a soft reset does not clear it
`timescale 1ns/1ps
`default_nettype none
`include "iadsr_defs.vh"

module iadsr_pin_class (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       pin_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output reg  [1:0] class_o
);

    reg seen_hi_r;
    reg seen_lo_r;
    reg diff_scl_r;
    reg diff_sda_r;
    reg [1:0] class_nxt;
    reg [`IADSR_WARM_W-1:0] warm_r;

    // keep the evidence across soft resets, otherwise an idle bus (both lines high)
    // would make a bus-tied pin look like a supply tie until the next start
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            seen_hi_r  <= 1'b0;
            seen_lo_r  <= 1'b0;
            diff_scl_r <= 1'b0;
            diff_sda_r <= 1'b0;
            warm_r     <= {`IADSR_WARM_W{1'b0}};
            class_o    <= `IADSR_CLS_HIGH;
        end
        else
        begin
            // the synchroniser resets to all ones; ignore it until that value is flushed,
            // else a grounded pin would collect false high evidence
            warm_r     <= {warm_r[`IADSR_WARM_W-2:0], 1'b1};
            seen_hi_r  <= seen_hi_r | (warm_r[`IADSR_WARM_W-1] & pin_i);
            seen_lo_r  <= seen_lo_r | (warm_r[`IADSR_WARM_W-1] & ~pin_i);
            diff_scl_r <= diff_scl_r | (warm_r[`IADSR_WARM_W-1] & (pin_i ^ scl_i));
            diff_sda_r <= diff_sda_r | (warm_r[`IADSR_WARM_W-1] & (pin_i ^ sda_i));
            class_o    <= class_nxt;
        end
    end

    always @*
    begin
        if (!seen_hi_r)
            class_nxt = `IADSR_CLS_LOW;
        else if (!seen_lo_r)
            class_nxt = `IADSR_CLS_HIGH;
        else if (!diff_scl_r)
            class_nxt = `IADSR_CLS_SCL;
        else
            class_nxt = `IADSR_CLS_SDA;
    end

endmodule

`default_nettype wire

// *** rtl/iadsr_sync.v ***
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs asynchronous to clk_i
// Notes:   output only changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module iadsr_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    input  wire         clk_i,
    input  wire         nrst_i,
    input  wire [W-1:0] async_i,
    output reg  [W-1:0] level_o
);

    reg [W-1:0] s1_r;
    reg [W-1:0] s2_r;
    reg [W-1:0] s3_r;
    integer     k;

    // s1_r feeds s2_r only
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1_r    <= INIT;
            s2_r    <= INIT;
            s3_r    <= INIT;
            level_o <= INIT;
        end
        else
        begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (k = 0; k < W; k = k + 1)
            begin
                if (s2_r[k] == s3_r[k])
                    level_o[k] <= s3_r[k];
            end
        end
    end

endmodule

`default_nettype wire

// *** rtl/iadsr_top.v ***
// Purpose: i2c target address recognition with broadcast software reset
// Assumes: scl and sda come from pins; target never stretches scl
// Notes:   own address is acknowledged but no port data is exchanged here
`timescale 1ns/1ps
`default_nettype none
`include "iadsr_defs.vh"

// Summary of operation
// - recognise own address, general call and identification address
// - software reset acts on the broadcast sequence alone, same on every instance
// - acknowledge the general call only when the whole first byte is 00h
// - general call with read bit gets no acknowledge and no reset action
// - after acknowledged general call, acknowledge a data byte equal to 06h
// - any other data byte is left unacknowledged and does not arm reset
// - after the reset byte, no further data byte is acknowledged
// - stop after an acknowledged reset byte returns the byte engine to power-up state; pin class evidence is kept
// - repeated start after the reset byte discards the armed reset
// - after reset, own address is answered again from the next start on
// - three select pins choose one of 64 addresses, compared after start
// - last address bit one means read, zero means write
// - reserved general call and identification codes never become own address
module iadsr_top (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       scl_i,
    input  wire       sda_i,
    input  wire       addr_select_pin_0_i,
    input  wire       addr_select_pin_1_i,
    input  wire       addr_select_pin_2_i,
    output reg        sda_o,
    output reg        sda_oe_o,
    output reg        soft_reset_o,
    output reg        addr_hit_o,
    output reg        read_o,
    output reg        id_hit_o,
    output reg        reset_armed_o,
    output reg  [6:0] own_addr_o
);

    // ****************************************************************
    // states
    // ****************************************************************
    localparam [4:0] ST_IDLE   = 5'h01;
    localparam [4:0] ST_ADDR   = 5'h02;
    localparam [4:0] ST_ACK    = 5'h04;
    localparam [4:0] ST_GCDATA = 5'h08;
    localparam [4:0] ST_IGNORE = 5'h10;

    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    wire [`IADSR_SYNC_W-1:0] pins_f;
    wire                     scl_f;
    wire                     sda_f;
    wire [1:0]               cls0;
    wire [1:0]               cls1;
    wire [1:0]               cls2;

    iadsr_sync #(
        .W    (`IADSR_SYNC_W),
        .INIT (5'h1f)
    ) u_sync (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i ({addr_select_pin_2_i, addr_select_pin_1_i, addr_select_pin_0_i, sda_i, scl_i}),
        .level_o (pins_f)
    );

    assign scl_f = pins_f[0];
    assign sda_f = pins_f[1];

    // ****************************************************************
    // address select pin classification
    // ****************************************************************
    iadsr_pin_class u_cls0 (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .pin_i   (pins_f[2]),
        .scl_i   (scl_f),
        .sda_i   (sda_f),
        .class_o (cls0)
    );

    iadsr_pin_class u_cls1 (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .pin_i   (pins_f[3]),
        .scl_i   (scl_f),
        .sda_i   (sda_f),
        .class_o (cls1)
    );

    iadsr_pin_class u_cls2 (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .pin_i   (pins_f[4]),
        .scl_i   (scl_f),
        .sda_i   (sda_f),
        .class_o (cls2)
    );

    // ****************************************************************
    // address map
    // ****************************************************************
    reg [3:0] grp_nib;
    wire [6:0] own_addr_nxt;

    // every group nibble is outside 0000 and 1111, so reserved codes cannot result
    always @*
    begin
        case ({cls2[1], cls1[1], cls0[1]})
            3'h0:    grp_nib = `IADSR_GRP_000;
            3'h1:    grp_nib = `IADSR_GRP_001;
            3'h2:    grp_nib = `IADSR_GRP_010;
            3'h3:    grp_nib = `IADSR_GRP_011;
            3'h4:    grp_nib = `IADSR_GRP_100;
            3'h5:    grp_nib = `IADSR_GRP_101;
            3'h6:    grp_nib = `IADSR_GRP_110;
            3'h7:    grp_nib = `IADSR_GRP_111;
            default: grp_nib = `IADSR_GRP_000;
        endcase
    end

    assign own_addr_nxt = {grp_nib, cls2[0], cls1[0], cls0[0]};

    // ****************************************************************
    // bus condition detection
    // ****************************************************************
    reg  scl_p_r;
    reg  sda_p_r;
    wire scl_rise;
    wire scl_fall;
    wire bus_start;
    wire bus_stop;

    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            scl_p_r <= 1'b1;
            sda_p_r <= 1'b1;
        end
        else
        begin
            scl_p_r <= scl_f;
            sda_p_r <= sda_f;
        end
    end

    assign scl_rise  = scl_f & ~scl_p_r;
    assign scl_fall  = ~scl_f & scl_p_r;
    assign bus_start = scl_f & scl_p_r & sda_p_r & ~sda_f;
    assign bus_stop  = scl_f & scl_p_r & ~sda_p_r & sda_f;

    // ****************************************************************
    // byte engine and reset sequencer
    // ****************************************************************
    reg [4:0]              state_r;
    reg [4:0]              state_nxt;
    reg [4:0]              after_ack_r;
    reg [4:0]              after_ack_nxt;
    reg [7:0]              shift_r;
    reg [7:0]              shift_nxt;
    reg [`IADSR_BITS_W-1:0] bits_r;
    reg [`IADSR_BITS_W-1:0] bits_nxt;
    reg                    arm_nxt;
    reg                    oe_nxt;
    reg                    hit_nxt;
    reg                    read_nxt;
    reg                    id_nxt;
    reg                    srst_nxt;

    always @*
    begin
        state_nxt     = state_r;
        after_ack_nxt = after_ack_r;
        shift_nxt     = shift_r;
        bits_nxt      = bits_r;
        arm_nxt       = reset_armed_o;
        oe_nxt        = sda_oe_o;
        hit_nxt       = 1'b0;
        read_nxt      = read_o;
        id_nxt        = 1'b0;
        srst_nxt      = 1'b0;
        if (bus_start)
        begin
            // a repeated start drops any armed reset
            state_nxt = ST_ADDR;
            bits_nxt  = {`IADSR_BITS_W{1'b0}};
            arm_nxt   = 1'b0;
            oe_nxt    = 1'b0;
        end
        else if (bus_stop)
        begin
            state_nxt = ST_IDLE;
            bits_nxt  = {`IADSR_BITS_W{1'b0}};
            oe_nxt    = 1'b0;
            arm_nxt   = 1'b0;
            srst_nxt  = reset_armed_o;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    oe_nxt = 1'b0;
                end
                ST_ADDR, ST_GCDATA:
                begin
                    if (scl_rise && bits_r != `IADSR_BYTE_BITS)
                    begin
                        shift_nxt = {shift_r[6:0], sda_f};
                        bits_nxt  = bits_r + 4'h1;
                    end
                    else if (scl_fall && bits_r == `IADSR_BYTE_BITS)
                    begin
                        state_nxt     = ST_IGNORE;
                        after_ack_nxt = ST_IGNORE;
                        if (state_r == ST_ADDR)
                        begin
                            if (shift_r == `IADSR_GC_WRITE)
                            begin
                                // whole byte must be 00h, not just the seven address bits
                                state_nxt     = ST_ACK;
                                after_ack_nxt = ST_GCDATA;
                            end
                            else if (shift_r == `IADSR_GC_READ)
                            begin
                                state_nxt = ST_IGNORE;
                            end
                            else if (shift_r[7:1] == own_addr_o)
                            begin
                                state_nxt = ST_ACK;
                                hit_nxt   = 1'b1;
                                read_nxt  = shift_r[0];
                            end
                            else if (shift_r[7:1] == `IADSR_ID_ADDR && !shift_r[0])
                            begin
                                state_nxt = ST_ACK;
                                id_nxt    = 1'b1;
                            end
                        end
                        else if (shift_r == `IADSR_RESET_BYTE)
                        begin
                            // only one reset byte per transfer is acknowledged
                            state_nxt = ST_ACK;
                            arm_nxt   = 1'b1;
                        end
                        else
                        begin
                            state_nxt = ST_IGNORE;
                        end
                        oe_nxt = (state_nxt == ST_ACK);
                    end
                end
                ST_ACK:
                begin
                    // release at the falling edge that ends the ninth clock
                    if (scl_fall)
                    begin
                        oe_nxt    = 1'b0;
                        state_nxt = after_ack_r;
                        bits_nxt  = {`IADSR_BITS_W{1'b0}};
                    end
                end
                ST_IGNORE:
                begin
                    oe_nxt = 1'b0;
                end
                default:
                begin
                    state_nxt = ST_IDLE;
                    oe_nxt    = 1'b0;
                end
            endcase
        end
    end

    // the ack cycle opens at the eighth falling edge and the very next falling
    // edge ends it, so the first data bit of the next byte is not lost
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_r       <= ST_IDLE;
            after_ack_r   <= ST_IGNORE;
            shift_r       <= 8'hff;
            bits_r        <= {`IADSR_BITS_W{1'b0}};
            sda_o         <= 1'b0;
            sda_oe_o      <= 1'b0;
            soft_reset_o  <= 1'b0;
            addr_hit_o    <= 1'b0;
            read_o        <= 1'b0;
            id_hit_o      <= 1'b0;
            reset_armed_o <= 1'b0;
            own_addr_o    <= {`IADSR_GRP_000, 3'h7};
        end
        else if (srst_nxt)
        begin
            // back to power-up values except own_addr_o and soft_reset_o; idle state is ready for the next start
            state_r       <= ST_IDLE;
            after_ack_r   <= ST_IGNORE;
            shift_r       <= 8'hff;
            bits_r        <= {`IADSR_BITS_W{1'b0}};
            sda_o         <= 1'b0;
            sda_oe_o      <= 1'b0;
            soft_reset_o  <= 1'b1;
            addr_hit_o    <= 1'b0;
            read_o        <= 1'b0;
            id_hit_o      <= 1'b0;
            reset_armed_o <= 1'b0;
            own_addr_o    <= own_addr_nxt;
        end
        else
        begin
            state_r       <= state_nxt;
            after_ack_r   <= after_ack_nxt;
            shift_r       <= shift_nxt;
            bits_r        <= bits_nxt;
            sda_o         <= 1'b0;
            sda_oe_o      <= oe_nxt;
            soft_reset_o  <= 1'b0;
            addr_hit_o    <= hit_nxt;
            read_o        <= read_nxt;
            id_hit_o      <= id_nxt;
            reset_armed_o <= arm_nxt;
            own_addr_o    <= own_addr_nxt;
        end
    end

endmodule

`default_nettype wire

// *** tb/iadsr_ctrl.sv ***
// Purpose: behavioural i2c bus controller for the target
// Assumes: 125 ns scl period; sda pull-up lives in the bench
// Notes:   scl rests high between frames, never runs free
`timescale 1ns/1ps
`default_nettype none

module iadsr_ctrl (
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_low_o
);
    // ****************
    // bus phases, a quarter period each
    // ****************
    localparam realtime QTR = 31.25;
    logic ack_r;
    event done_e;

    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        ack_r = 1'b0;
    end

    // works from idle and as a repeated start after an ack bit
    task automatic start_c();
        begin
            sda_low_o = 1'b0;
            #(QTR) scl_o = 1'b1;
            #(QTR) sda_low_o = 1'b1;
            #(QTR) scl_o = 1'b0;
            #(QTR);
        end
    endtask

    task automatic stop_c();
        begin
            sda_low_o = 1'b1;
            #(QTR) scl_o = 1'b1;
            #(QTR) sda_low_o = 1'b0;
            #(4*QTR);
        end
    endtask

    // msb first, then a ninth clock with sda released for the ack
    task automatic byte_c(input logic [7:0] b);
        int i;
        begin
            for (i = 7; i >= 0; i--)
            begin
                sda_low_o = ~b[i];
                #(QTR) scl_o = 1'b1;
                #(2*QTR) scl_o = 1'b0;
                #(QTR);
            end
            sda_low_o = 1'b0;
            #(QTR) scl_o = 1'b1;
            #(QTR) ack_r = ~sda_i;
            #(QTR) scl_o = 1'b0;
            #(QTR) -> done_e;
        end
    endtask
endmodule
`default_nettype wire

// *** tb/iadsr_monitor.sv ***
// Purpose: port checker for iadsr_top
// Assumes: controller never stretches scl; sda changes while scl is high only for start and stop
// Notes:   bound to every iadsr_top instance
`timescale 1ns/1ps
`default_nettype none
`include "iadsr_defs.vh"

module iadsr_monitor (
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       addr_select_pin_0_i,
    input wire logic       addr_select_pin_1_i,
    input wire logic       addr_select_pin_2_i,
    input wire logic       sda_o,
    input wire logic       sda_oe_o,
    input wire logic       soft_reset_o,
    input wire logic       addr_hit_o,
    input wire logic       read_o,
    input wire logic       id_hit_o,
    input wire logic       reset_armed_o,
    input wire logic [6:0] own_addr_o
);
    // ****************
    // bus events and properties
    // ****************
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // raw pin events; the design sees them a few clocks later through its filter
    sequence s_armed_stop;
        reset_armed_o ##0 (scl_i && $rose(sda_i));
    endsequence
    sequence s_armed_restart;
        reset_armed_o ##0 (scl_i && $fell(sda_i));
    endsequence

    property p_ack_holds;
        $rose(sda_oe_o) |-> sda_oe_o [*8];
    endproperty
    property p_ack_ends;
        $rose(sda_oe_o) |-> ##[9:30] !sda_oe_o;
    endproperty
    property p_drive_low;
        sda_oe_o |-> !sda_o;
    endproperty
    property p_hit_ack;
        addr_hit_o |-> $rose(sda_oe_o);
    endproperty
    property p_id_ack;
        id_hit_o |-> $rose(sda_oe_o);
    endproperty
    property p_arm_ack;
        $rose(reset_armed_o) |-> $rose(sda_oe_o);
    endproperty
    property p_reset_cause;
        soft_reset_o |-> $past(reset_armed_o) && !reset_armed_o;
    endproperty
    property p_stop_resets;
        s_armed_stop |-> ##[2:12] soft_reset_o;
    endproperty
    property p_restart_drops;
        s_armed_restart |-> ##[2:12] !reset_armed_o;
    endproperty
    property p_restart_quiet;
        s_armed_restart |-> (!soft_reset_o) [*8];
    endproperty
    property p_own_free;
        own_addr_o != 7'h00 && own_addr_o != `IADSR_ID_ADDR;
    endproperty

    a_ack_holds: assert property (p_ack_holds) else $error("ack released early");
    a_ack_ends: assert property (p_ack_ends) else $error("ack not released");
    a_drive_low: assert property (p_drive_low) else $error("sda driven high");
    a_hit_ack: assert property (p_hit_ack) else $error("address hit without ack");
    a_id_ack: assert property (p_id_ack) else $error("id hit without ack");
    a_arm_ack: assert property (p_arm_ack) else $error("armed without ack");
    a_reset_cause: assert property (p_reset_cause) else $error("reset while not armed");
    a_stop_resets: assert property (p_stop_resets) else $error("stop gave no reset");
    a_restart_drops: assert property (p_restart_drops) else $error("restart kept arming");
    a_restart_quiet: assert property (p_restart_quiet) else $error("restart gave reset");
    a_own_free: assert property (p_own_free) else $error("own address reserved");
endmodule

bind iadsr_top iadsr_monitor u_mon (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i),
    .addr_select_pin_0_i(addr_select_pin_0_i), .addr_select_pin_1_i(addr_select_pin_1_i),
    .addr_select_pin_2_i(addr_select_pin_2_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .soft_reset_o(soft_reset_o), .addr_hit_o(addr_hit_o), .read_o(read_o), .id_hit_o(id_hit_o),
    .reset_armed_o(reset_armed_o), .own_addr_o(own_addr_o)
);
`default_nettype wire

// *** tb/test_iadsr_top.sv ***
// Purpose: self-checking bench for iadsr_top
// Assumes: one controller; pins tied by a random class per reset
// Notes:   expected acks are queued and judged by a watcher
`timescale 1ns/1ps
`default_nettype none

module test_iadsr_top;
    logic       clk_i;
    logic       nrst_i;
    wire        scl_w, sda_low_w, sda_w, oe_w, so_w, sr_w, hit_w, rd_w, id_w, arm_w;
    wire  [2:0] pin_w;
    wire  [6:0] own_w;
    logic [1:0] cls [0:2];
    logic [3:0] grp [0:7] = '{4'h4, 4'h5, 4'h2, 4'h3, 4'hc, 4'he, 4'ha, 4'hb};
    logic       exp_q [$];
    int         mismatches = 0;
    int         num_checks = 0;
    int         cycles = 0;
    int         n_sr = 0, n_hit = 0, n_id = 0, e_sr = 0, e_hit = 0, e_id = 0;

    // ****************
    // bus wiring and design
    // ****************
    // pull-up: a released sda reads high
    assign sda_w = ~(sda_low_w | (oe_w & ~so_w));
    assign pin_w[0] = cls[0][1] ? (cls[0][0] ? sda_w : scl_w) : cls[0][0];
    assign pin_w[1] = cls[1][1] ? (cls[1][0] ? sda_w : scl_w) : cls[1][0];
    assign pin_w[2] = cls[2][1] ? (cls[2][0] ? sda_w : scl_w) : cls[2][0];

    iadsr_top dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_w), .sda_i(sda_w),
        .addr_select_pin_0_i(pin_w[0]), .addr_select_pin_1_i(pin_w[1]), .addr_select_pin_2_i(pin_w[2]),
        .sda_o(so_w), .sda_oe_o(oe_w), .soft_reset_o(sr_w), .addr_hit_o(hit_w), .read_o(rd_w),
        .id_hit_o(id_w), .reset_armed_o(arm_w), .own_addr_o(own_w)
    );
    iadsr_ctrl u_ctrl (.sda_i(sda_w), .scl_o(scl_w), .sda_low_o(sda_low_w));

    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        n_sr <= n_sr + int'(sr_w === 1'b1);
        n_hit <= n_hit + int'(hit_w === 1'b1);
        n_id <= n_id + int'(id_w === 1'b1);
        if (cycles == 40000)
        begin
            mismatches++;
            conclude();
        end
    end

    // ****************
    // checking
    // ****************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        begin
            num_checks++;
            if (seen !== exp)
            begin
                mismatches++;
                $display("BAD %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    task conclude();
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    initial
    forever
    begin
        @(u_ctrl.done_e);
        check("ack", {7'h00, u_ctrl.ack_r}, {7'h00, exp_q.pop_front()});
    end

    task automatic xfer(input logic [7:0] b, input logic e);
        begin
            exp_q.push_back(e);
            u_ctrl.byte_c(b);
        end
    endtask

    task automatic tally(input string name);
        begin
            repeat (2) @(negedge clk_i);
            check("resets", n_sr[7:0], e_sr[7:0]);
            check("hits", n_hit[7:0], e_hit[7:0]);
            check("id hits", n_id[7:0], e_id[7:0]);
            $display("test %s done", name);
        end
    endtask

    task automatic arm();
        begin
            xfer(8'h00, 1'b1);
            xfer(8'h06, 1'b1);
            @(negedge clk_i);
            check("armed", {7'h00, arm_w}, 8'h01);
        end
    endtask

    // ****************
    // one pin configuration per reset
    // ****************
    task automatic run_cfg();
        logic       rw;
        logic [6:0] own;
        begin
            @(negedge clk_i);
            nrst_i = 1'b0;
            foreach (cls[k])
                cls[k] = 2'($urandom % 4);
            own = {grp[{cls[2][1], cls[1][1], cls[0][1]}], cls[2][0], cls[1][0], cls[0][0]};
            rw = 1'($urandom % 2);
            repeat (6) @(negedge clk_i);
            nrst_i = 1'b1;
            repeat (10) @(negedge clk_i);
            u_ctrl.start_c();
            xfer(8'h01, 1'b0);
            u_ctrl.stop_c();
            tally("gc read");
            check("own addr", {1'b0, own_w}, {1'b0, own});
            u_ctrl.start_c();
            xfer({own, rw}, 1'b1);
            e_hit++;
            u_ctrl.stop_c();
            check("read", {7'h00, rd_w}, {7'h00, rw});
            u_ctrl.start_c();
            xfer({own ^ 7'h01, 1'b0}, 1'b0);
            u_ctrl.stop_c();
            u_ctrl.start_c();
            xfer(8'hf8, 1'b1);
            e_id++;
            u_ctrl.stop_c();
            tally("own and id");
            u_ctrl.start_c();
            xfer(8'h00, 1'b1);
            xfer(8'h07, 1'b0);
            check("armed", {7'h00, arm_w}, 8'h00);
            u_ctrl.stop_c();
            tally("wrong byte");
            u_ctrl.start_c();
            arm();
            u_ctrl.start_c();
            @(negedge clk_i);
            check("armed", {7'h00, arm_w}, 8'h00);
            xfer({own, 1'b0}, 1'b1);
            e_hit++;
            u_ctrl.stop_c();
            tally("restart");
            u_ctrl.start_c();
            arm();
            xfer(8'h06, 1'b0);
            u_ctrl.stop_c();
            e_sr++;
            tally("reset");
            u_ctrl.start_c();
            xfer({own, 1'b0}, 1'b1);
            e_hit++;
            u_ctrl.stop_c();
            tally("after reset");
        end
    endtask

    initial
    begin
        nrst_i = 1'b0;
        cls = '{2'h1, 2'h1, 2'h1};
        void'($urandom(80143));
        repeat (2) run_cfg();
        conclude();
    end
endmodule
`default_nettype wire
